// ===== ccs_cfg.svh
// Register map, field positions, reset values and codes of the clock output block.
`ifndef CCS_CFG_SVH
`define CCS_CFG_SVH

`define CCS_OFF_REFREP 8'h00
`define CCS_OFF_TRIG 8'h04
`define CCS_OFF_AUX 8'h08
`define CCS_OFF_STATUS 8'h0c

`define CCS_REFREP_EN_BIT 0
`define CCS_TRIG_EN_BIT 0
`define CCS_TRIG_MODE_LSB 1
`define CCS_TRIG_DIV_LSB 8
`define CCS_TRIG_MODE_TS 2'h3

`define CCS_REFREP_RST 32'h0000_0001
`define CCS_TRIG_RST 32'h0000_0200
`define CCS_AUX_RST 32'h0000_0000
`define CCS_REFREP_MASK 32'h0000_0001
`define CCS_TRIG_MASK 32'h0000_ff07
`define CCS_AUX_MASK 32'h0000_003f

`define CCS_DIV_MIN 8'h02
`define CCS_DIV_TWO 8'h02
`define CCS_DIV_FOUR 8'h04

`define CCS_RESP_OKAY 2'h0
`define CCS_RESP_SLVERR 2'h2

`endif

// ===== ccs_pkg.sv
// Types shared by the clock output block.
package ccs_pkg;

  typedef enum logic [2:0] {
    CCS_SRC_OFF,
    CCS_SRC_REF,
    CCS_SRC_DIV2,
    CCS_SRC_DIV4,
    CCS_SRC_OVR
  } ccs_src_e;

  typedef struct packed {
    logic diff_clk;
    logic se_ref;
    logic se_sel;
    logic pll_en;
    logic pd;
    logic [1:0] cfg;
    logic tstamp;
    logic ser_clk;
    logic ovr_c;
    logic ovr_d;
    logic quad;
    logic frame_ref;
  } ccs_pins_s;

  typedef struct packed {
    logic overrange_output_enable;
    logic [1:0] out_d_divider_mode;
    logic [1:0] out_c_divider_mode;
    logic pin_override_enable;
  } ccs_aux_ctrl_s;

endpackage

// ===== ccs_div.sv
// Event-counting clock divider with a nominal fifty percent duty cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_cfg.svh"
module ccs_div (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire logic tick,
  input wire logic [7:0] ratio,
  // Divided output.
  output logic clk_out
);

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [7:0] ratio_eff;
  logic out_reg;

  // Ratios below two are treated as two.
  assign ratio_eff = (ratio < `CCS_DIV_MIN) ? `CCS_DIV_MIN : ratio;
  assign cnt_next = (cnt_reg >= ratio_eff - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
  assign clk_out = out_reg;

  always_ff @(posedge clk) begin
    if (rst || !run) begin
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else if (tick) begin
      cnt_reg <= cnt_next;
      out_reg <= cnt_next < (ratio_eff >> 1);
    end
  end

endmodule
`default_nettype wire

// ===== ccs_top.sv
// Auxiliary clock outputs, trigger output and frame reference capture with an AXI4-Lite register port.
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ccs_cfg.svh"
module ccs_top
  import ccs_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write channels.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins.
  input wire logic diff_clock_input,
  input wire logic single_ended_clock_input,
  input wire logic single_ended_ref_select,
  input wire logic pll_enable_pin,
  input wire logic power_down_pin,
  input wire logic [1:0] clock_config_pins,
  input wire logic timestamp_input,
  input wire logic serializer_clock,
  input wire logic overrange_flag_c,
  input wire logic overrange_flag_d,
  input wire logic quad_variant,
  input wire logic frame_ref_input,
  // Clock and event outputs.
  output logic ref_repeat_out,
  output logic trigger_clock_out,
  output logic aux_clock_out_c,
  output logic aux_clock_out_d,
  output logic frame_ref_capture
);

  // ************************************************************
  // Functions
  // ************************************************************

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr);
    return addr == `CCS_OFF_REFREP || addr == `CCS_OFF_TRIG ||
           addr == `CCS_OFF_AUX || addr == `CCS_OFF_STATUS;
  endfunction

  function automatic ccs_src_e aux_src(input logic ovr, input logic [1:0] cfg, input logic [1:0] mode,
                                       input logic flag_en, input logic quad, input logic is_d,
                                       input logic [1:0] c_mode);
    ccs_src_e s;
    logic [1:0] code;
    code = ovr ? mode : cfg;
    s = CCS_SRC_OFF;
    if (code == 2'h0) begin
      if (flag_en && quad) begin
        s = CCS_SRC_OVR;
      end
    end else if (is_d && !ovr) begin
      s = CCS_SRC_REF;
    end else if (is_d && c_mode == 2'h0) begin
      s = CCS_SRC_OFF;
    end else begin
      case (code)
        2'h1: s = CCS_SRC_REF;
        2'h2: s = CCS_SRC_DIV2;
        default: s = CCS_SRC_DIV4;
      endcase
    end
    return s;
  endfunction

  function automatic logic aux_level(input ccs_src_e s, input logic ref_lvl, input logic d2,
                                     input logic d4, input logic flag);
    logic v;
    case (s)
      CCS_SRC_REF: v = ref_lvl;
      CCS_SRC_DIV2: v = d2;
      CCS_SRC_DIV4: v = d4;
      CCS_SRC_OVR: v = flag;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************

  ccs_pins_s pins_raw;
  ccs_pins_s sync1_reg;
  ccs_pins_s sync2_reg;
  ccs_pins_s prev_reg;

  assign pins_raw = '{diff_clk: diff_clock_input, se_ref: single_ended_clock_input,
                      se_sel: single_ended_ref_select, pll_en: pll_enable_pin,
                      pd: power_down_pin, cfg: clock_config_pins, tstamp: timestamp_input,
                      ser_clk: serializer_clock, ovr_c: overrange_flag_c,
                      ovr_d: overrange_flag_d, quad: quad_variant, frame_ref: frame_ref_input};

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  logic sel_ref;
  logic sel_prev;
  logic ref_rise;
  logic ser_rise;
  logic frame_edge;
  logic pd;

  assign sel_ref = sync2_reg.se_sel ? sync2_reg.se_ref : sync2_reg.diff_clk;
  assign sel_prev = prev_reg.se_sel ? prev_reg.se_ref : prev_reg.diff_clk;
  assign ref_rise = sel_ref & ~sel_prev;
  assign ser_rise = sync2_reg.ser_clk & ~prev_reg.ser_clk;
  assign frame_edge = sync2_reg.frame_ref & ~prev_reg.frame_ref;
  assign pd = sync2_reg.pd;

  // ************************************************************
  // AXI4-Lite slave
  // ************************************************************

  logic awready_reg;
  logic aw_held_reg;
  logic [7:0] awaddr_reg;
  logic wready_reg;
  logic w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do;

  assign aw_fire = s_axi_awvalid & awready_reg;
  assign w_fire = s_axi_wvalid & wready_reg;
  assign ar_fire = s_axi_arvalid & arready_reg;
  assign wr_do = aw_held_reg & w_held_reg & ~bvalid_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (aw_fire) begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_do) begin
      awready_reg <= 1'b1;
      aw_held_reg <= 1'b0;
    end else begin
      awready_reg <= ~aw_held_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else if (w_fire) begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_do) begin
      wready_reg <= 1'b1;
      w_held_reg <= 1'b0;
    end else begin
      wready_reg <= ~w_held_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `CCS_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= reg_hit(awaddr_reg) ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************

  logic [31:0] refrep_reg;
  logic [31:0] trig_reg;
  logic [31:0] aux_reg;
  ccs_aux_ctrl_s aux_ctrl;
  logic [1:0] trig_mode;
  logic trig_on;

  assign aux_ctrl = aux_reg[5:0];
  assign trig_mode = trig_reg[`CCS_TRIG_MODE_LSB +: 2];
  assign trig_on = trig_reg[`CCS_TRIG_EN_BIT] & ~pd;

  always_ff @(posedge clk) begin
    if (rst) begin
      refrep_reg <= `CCS_REFREP_RST;
      trig_reg <= `CCS_TRIG_RST;
      aux_reg <= `CCS_AUX_RST;
    end else if (wr_do) begin
      case (awaddr_reg)
        `CCS_OFF_REFREP: refrep_reg <= merge(refrep_reg, wdata_reg, wstrb_reg, `CCS_REFREP_MASK);
        `CCS_OFF_TRIG: trig_reg <= merge(trig_reg, wdata_reg, wstrb_reg, `CCS_TRIG_MASK);
        `CCS_OFF_AUX: aux_reg <= merge(aux_reg, wdata_reg, wstrb_reg, `CCS_AUX_MASK);
        default: refrep_reg <= refrep_reg;
      endcase
    end
  end

  // ************************************************************
  // Dividers
  // ************************************************************

  logic ref_div2;
  logic ref_div4;
  logic ser_div;

  ccs_div u_div2 (
    .clk(clk),
    .rst(rst),
    .run(~pd),
    .tick(ref_rise),
    .ratio(`CCS_DIV_TWO),
    .clk_out(ref_div2)
  );

  ccs_div u_div4 (
    .clk(clk),
    .rst(rst),
    .run(~pd),
    .tick(ref_rise),
    .ratio(`CCS_DIV_FOUR),
    .clk_out(ref_div4)
  );

  ccs_div u_ser_div (
    .clk(clk),
    .rst(rst),
    .run(trig_on && trig_mode != `CCS_TRIG_MODE_TS),
    .tick(ser_rise),
    .ratio(trig_reg[`CCS_TRIG_DIV_LSB +: 8]),
    .clk_out(ser_div)
  );

  // ************************************************************
  // Output selection
  // ************************************************************

  ccs_src_e src_c;
  ccs_src_e src_d;

  assign src_c = aux_src(aux_ctrl.pin_override_enable, sync2_reg.cfg, aux_ctrl.out_c_divider_mode,
                         aux_ctrl.overrange_output_enable, sync2_reg.quad, 1'b0,
                         aux_ctrl.out_c_divider_mode);
  assign src_d = aux_src(aux_ctrl.pin_override_enable, sync2_reg.cfg, aux_ctrl.out_d_divider_mode,
                         aux_ctrl.overrange_output_enable, sync2_reg.quad, 1'b1,
                         aux_ctrl.out_c_divider_mode);

  logic ref_repeat_reg;
  logic trig_out_reg;
  logic aux_c_reg;
  logic aux_d_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_repeat_reg <= 1'b0;
    end else begin
      ref_repeat_reg <= refrep_reg[`CCS_REFREP_EN_BIT] & sync2_reg.pll_en & ~pd & sel_ref;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trig_out_reg <= 1'b0;
    end else if (!trig_on) begin
      trig_out_reg <= 1'b0;
    end else if (trig_mode == `CCS_TRIG_MODE_TS) begin
      trig_out_reg <= sync2_reg.tstamp;
    end else begin
      trig_out_reg <= ser_div;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aux_c_reg <= 1'b0;
      aux_d_reg <= 1'b0;
    end else begin
      aux_c_reg <= ~pd & aux_level(src_c, sel_ref, ref_div2, ref_div4, sync2_reg.ovr_c);
      aux_d_reg <= ~pd & aux_level(src_d, sel_ref, ref_div2, ref_div4, sync2_reg.ovr_d);
    end
  end

  // ************************************************************
  // Frame reference capture
  // ************************************************************

  logic frame_pend_reg;
  logic frame_cap_reg;
  logic [15:0] frame_cnt_reg;

  // A new edge in the same cycle as a capture keeps the pending flag set.
  always_ff @(posedge clk) begin
    if (rst || pd) begin
      frame_pend_reg <= 1'b0;
    end else if (frame_edge) begin
      frame_pend_reg <= 1'b1;
    end else if (ref_rise) begin
      frame_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_cap_reg <= 1'b0;
      frame_cnt_reg <= 16'h0000;
    end else begin
      frame_cap_reg <= frame_pend_reg & ref_rise & ~pd;
      if (frame_cap_reg) begin
        frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************

  logic [31:0] status_word;
  logic [31:0] rd_word;

  assign status_word = {frame_cnt_reg, 3'h0, sync2_reg.cfg, pd, sync2_reg.pll_en, sync2_reg.se_sel,
                        src_d, src_c, trig_out_reg | trig_on, ref_repeat_reg | (sync2_reg.pll_en & ~pd)};

  always_comb begin
    case (s_axi_araddr)
      `CCS_OFF_REFREP: rd_word = refrep_reg;
      `CCS_OFF_TRIG: rd_word = trig_reg;
      `CCS_OFF_AUX: rd_word = aux_reg;
      `CCS_OFF_STATUS: rd_word = status_word;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `CCS_RESP_OKAY;
    end else if (ar_fire) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= reg_hit(s_axi_araddr) ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end else begin
      arready_reg <= ~rvalid_reg;
    end
  end

  // ************************************************************
  // Output ports
  // ************************************************************

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign ref_repeat_out = ref_repeat_reg;
  assign trigger_clock_out = trig_out_reg;
  assign aux_clock_out_c = aux_c_reg;
  assign aux_clock_out_d = aux_d_reg;
  assign frame_ref_capture = frame_cap_reg;

endmodule
`default_nettype wire

// ===== ccs_top_asserts.sv
// Concurrent checks on the ports of the clock output block.
`timescale 1ns/1ps
`default_nettype none
module ccs_top_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device pins.
  input wire logic diff_clock_input,
  input wire logic single_ended_clock_input,
  input wire logic single_ended_ref_select,
  input wire logic pll_enable_pin,
  input wire logic power_down_pin,
  // Clock and event outputs.
  input wire logic ref_repeat_out,
  input wire logic trigger_clock_out,
  input wire logic aux_clock_out_c,
  input wire logic aux_clock_out_d,
  input wire logic frame_ref_capture
);
  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_b_after_w: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_refrep_src: assert property (ref_repeat_out |->
    ($past(single_ended_ref_select, 3) ? $past(single_ended_clock_input, 3) : $past(diff_clock_input, 3)))
    else $error("repeat output not from selected reference");
  chk_refrep_pll: assert property (!pll_enable_pin [*4] |-> !ref_repeat_out)
    else $error("repeat output on without pll");
  chk_refrep_pd: assert property (power_down_pin [*4] |-> !ref_repeat_out)
    else $error("repeat output on in power down");
  chk_trig_pd: assert property (power_down_pin [*4] |-> !trigger_clock_out)
    else $error("trigger output on in power down");
  chk_aux_pd: assert property (power_down_pin [*4] |-> !aux_clock_out_c && !aux_clock_out_d)
    else $error("aux output on in power down");
  chk_cap_pulse: assert property (frame_ref_capture |=> !frame_ref_capture)
    else $error("capture pulse too long");
  cov_write: cover property (s_axi_bvalid && s_axi_bready);
  cov_capture: cover property (frame_ref_capture);
  cov_aux_d: cover property ($rose(aux_clock_out_d));
endmodule
bind ccs_top ccs_top_chk chk_i (.*);
`default_nettype wire

// ===== ccs_far_model.sv
// Far-side model: reference clocks, serializer clock, timestamp and frame reference.
`timescale 1ns/1ps
`default_nettype none
module ccs_far_model (
  // Clock and commands.
  input wire logic clk,
  input wire logic fr_run,
  input wire logic fr_shot,
  // Pins toward the block.
  output logic diff_clock_input,
  output logic single_ended_clock_input,
  output logic serializer_clock,
  output logic timestamp_input,
  output logic frame_ref_input
);
  logic [7:0] t_reg = 8'h00;
  logic [3:0] s_reg = 4'h0;
  logic [5:0] f_reg = 6'h00;
  logic [3:0] shot_reg = 4'h0;
  always_ff @(posedge clk) t_reg <= t_reg + 8'h01;
  always_ff @(posedge clk) s_reg <= (s_reg == 4'hb) ? 4'h0 : s_reg + 4'h1;
  // The periodic frame reference spans eight reference periods, one multiframe or extended multiblock.
  always_ff @(posedge clk) f_reg <= fr_run ? f_reg + 6'h01 : 6'h00;
  always_ff @(posedge clk) shot_reg <= fr_shot ? 4'h8 : shot_reg - {3'h0, shot_reg != 4'h0};
  assign diff_clock_input = t_reg[2];
  assign single_ended_clock_input = s_reg < 4'h6;
  assign serializer_clock = t_reg[1];
  assign timestamp_input = t_reg[5] ^ t_reg[7];
  // One source feeds the frame reference to every chained part.
  assign frame_ref_input = (fr_run && f_reg < 6'h08) || shot_reg != 4'h0;
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench of the clock output block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk, rst = 1'b1, fr_run = 1'b0, fr_shot = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic single_ended_ref_select = 1'b0, pll_enable_pin = 1'b1, power_down_pin = 1'b0, quad_variant = 1'b0;
  logic overrange_flag_c = 1'b0, overrange_flag_d = 1'b0;
  logic [1:0] clock_config_pins = 2'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd, v;
  logic diff_clock_input, single_ended_clock_input, timestamp_input, serializer_clock, frame_ref_input;
  logic ref_repeat_out, trigger_clock_out, aux_clock_out_c, aux_clock_out_d, frame_ref_capture;
  logic [15:0] c0;
  logic [4:0] mon;
  int mismatches = 0, check_count = 0, cnt[5], e;
  integer seed = 32'hd8ded479;
  int tab[6][4] = '{'{5, 0, 6, 0}, '{15, 0, 3, 12}, '{19, 0, 12, 6}, '{9, 0, 0, 0}, '{0, 2, 6, 12}, '{0, 3, 3, 12}};
  assign mon = {timestamp_input, aux_clock_out_d, aux_clock_out_c, trigger_clock_out, ref_repeat_out};
  ccs_top uut (.*);
  ccs_far_model far (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // Bus tasks and expectations.
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rdr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    `CHK(rd & m, ex)
    `CHK(s_axi_rresp, er)
  endtask
  // Counts rising edges of the watched outputs after a short settling time.
  task automatic rises(input int n);
    logic [4:0] p;
    repeat (16) @(posedge clk);
    p = mon;
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge clk);
      for (int i = 0; i < 5; i++) if (mon[i] && !p[i]) cnt[i]++;
      p = mon;
    end
  endtask
  function automatic logic near(int c, int x);
    return x == 0 ? c == 0 : (c >= x - 1 && c <= x + 1);
  endfunction
  function automatic logic [2:0] exp_c(logic [5:0] a, logic [1:0] g, logic q);
    logic [1:0] k;
    k = a[0] ? a[2:1] : g;
    return k != 2'h0 ? {1'b0, k} : (a[5] && q ? 3'h4 : 3'h0);
  endfunction
  function automatic logic [2:0] exp_d(logic [5:0] a, logic [1:0] g, logic q);
    logic [2:0] o;
    o = a[5] && q ? 3'h4 : 3'h0;
    if (!a[0]) return g != 2'h0 ? 3'h1 : o;
    if (a[4:3] == 2'h0) return o;
    return a[2:1] == 2'h0 ? 3'h0 : {1'b0, a[4:3]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdr(8'h00, '1, 32'h1, 2'h0);
    rdr(8'h04, '1, 32'h200, 2'h0);
    rdr(8'h08, '1, 32'h0, 2'h0);
    rises(96);
    `CHK(cnt[1], 0)
    `CHK(near(cnt[0], 12), 1'b1)
    single_ended_ref_select <= 1'b1;
    rises(96);
    `CHK(near(cnt[0], 8), 1'b1)
    single_ended_ref_select <= 1'b0;
    wr(8'h00, 32'h0, 2'h0);
    rises(96);
    `CHK(cnt[0], 0)
    wr(8'h00, 32'h1, 2'h0);
    pll_enable_pin <= 1'b0;
    rises(96);
    `CHK(cnt[0], 0)
    pll_enable_pin <= 1'b1;
    wr(8'h08, '1, 2'h0);
    rdr(8'h08, '1, 32'h3f, 2'h0);
    wr(8'h04, '1, 2'h0);
    rdr(8'h04, '1, 32'hff07, 2'h0);
    wr(8'h10, '1, 2'h2);
    rdr(8'h10, '1, 32'h0, 2'h2);
    wr(8'h0c, '1, 2'h0);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(8'h08, tab[i][0], 2'h0);
      clock_config_pins <= tab[i][1][1:0];
      rises(96);
      `CHK(near(cnt[2], tab[i][2]), 1'b1)
      `CHK(near(cnt[3], tab[i][3]), 1'b1)
    end
    $display("test aux waveforms done");
    repeat (32) begin
      v = $random(seed);
      clock_config_pins <= v[9:8];
      quad_variant <= v[10];
      overrange_flag_c <= v[11];
      overrange_flag_d <= v[12];
      wr(8'h08, {26'h0, v[5:0]}, 2'h0);
      repeat (4) @(posedge clk);
      rdr(8'h0c, 32'h1fc, {24'h0, exp_d(v[5:0], v[9:8], v[10]), exp_c(v[5:0], v[9:8], v[10]), 2'h0}, 2'h0);
    end
    $display("test aux decode done");
    for (int d = 0; d < 12; d += 4) begin
      wr(8'h04, (d << 8) | ((d >> 2) << 1) | 1, 2'h0);
      e = 24 / (d < 2 ? 2 : d);
      rises(96);
      `CHK(near(cnt[1], e), 1'b1)
    end
    wr(8'h04, 32'h7, 2'h0);
    rises(96);
    `CHK(near(cnt[1], cnt[4]), 1'b1)
    $display("test trigger done");
    rdr(8'h0c, 32'h1f00, {19'h0, v[9:8], 3'h2, 8'h0}, 2'h0);
    c0 = rd[31:16];
    fr_shot <= 1'b1;
    @(posedge clk);
    fr_shot <= 1'b0;
    repeat (40) @(posedge clk);
    rdr(8'h0c, 32'hffff0000, {c0 + 16'h1, 16'h0}, 2'h0);
    c0 = rd[31:16];
    fr_run <= 1'b1;
    repeat (320) @(posedge clk);
    fr_run <= 1'b0;
    repeat (40) @(posedge clk);
    rdr(8'h0c, 32'hffff0000, {c0 + 16'h5, 16'h0}, 2'h0);
    $display("test frame reference done");
    wr(8'h08, 32'hf, 2'h0);
    wr(8'h04, 32'h401, 2'h0);
    power_down_pin <= 1'b1;
    rises(96);
    `CHK(cnt[0] + cnt[1], 0)
    `CHK(cnt[2] + cnt[3], 0)
    $display("test power down done");
    report_and_stop;
  end
  initial begin
    repeat (8000) @(posedge clk);
    mismatches++;
    report_and_stop;
  end
endmodule
`default_nettype wire
